// file: rtl/iap_flash_defines.svh
`ifndef IAP_FLASH_DEFINES_SVH
`define IAP_FLASH_DEFINES_SVH

// register indices on the special-register port
`define IDX_FLASH_CTRL_MODE          4'h0
`define IDX_CHIP_RESET_KEY           4'h1
`define IDX_FLASH_TIMING_BUFFER_CTRL 4'h2
`define IDX_FLASH_ADDR_LOW           4'h3
`define IDX_FLASH_ADDR_HIGH          4'h4
`define IDX_DATA_WORD0_LOW           4'h5
`define IDX_DATA_WORD0_HIGH          4'h6
`define IDX_DATA_WORD1_LOW           4'h7
`define IDX_DATA_WORD1_HIGH          4'h8
`define IDX_DATA_WORD2_LOW           4'h9
`define IDX_DATA_WORD2_HIGH          4'hA
`define IDX_DATA_WORD3_LOW           4'hB
`define IDX_DATA_WORD3_HIGH          4'hC

// flash_ctrl_mode fields
`define CM_ERASE_WRITE_ENABLED       7
`define CM_MODE_HI                   6
`define CM_MODE_LO                   4
`define CM_ENABLE_PROC_TRIGGER       3
`define CM_WRITE_INITIATE            2
`define CM_READ_ENABLE               1
`define CM_READ_INITIATE             0

// flash_timing_buffer_ctrl fields
`define TB_OP_TIME_SELECT            1
`define TB_BUFFER_CLEAR              0

// flash_addr_high implemented width
`define ADDR_HIGH_BITS               4

// reset values
`define RST_BYTE                     8'h00
`define RST_ADDR                     12'h000
`define RST_MODE                     3'h0

// enable key, words 1..3 low then high
`define KEY_WORD1_LOW                8'h00
`define KEY_WORD2_LOW                8'h0D
`define KEY_WORD3_LOW                8'hC3
`define KEY_WORD1_HIGH               8'h04
`define KEY_WORD2_HIGH               8'h09
`define KEY_WORD3_HIGH               8'h40

`define CHIP_RESET_PATTERN           8'h55
`define PAGE_LAST_WORD               5'h1F

// timing
`define CLK_PERIOD_NS                8
`define ERASE_TIME0_US               3200
`define WRITE_TIME0_US               2200
`define ERASE_TIME1_US               3700
`define WRITE_TIME1_US               3000
`define ERASE_TIME0_CYC              (`ERASE_TIME0_US * 1000 / `CLK_PERIOD_NS)
`define WRITE_TIME0_CYC              (`WRITE_TIME0_US * 1000 / `CLK_PERIOD_NS)
`define ERASE_TIME1_CYC              (`ERASE_TIME1_US * 1000 / `CLK_PERIOD_NS)
`define WRITE_TIME1_CYC              (`WRITE_TIME1_US * 1000 / `CLK_PERIOD_NS)
`define ENABLE_TIMEOUT_CYC           1024
`define READ_CYC                     2

`endif

// file: rtl/iap_flash_pkg.sv
package iap_flash_pkg;

   typedef enum logic [2:0] {
      OP_WRITE  = 3'h0,
      OP_ERASE  = 3'h1,
      OP_READ   = 3'h3,
      OP_ENABLE = 3'h6
   } op_mode_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_PROG  = 5'h02,
      ST_WAIT  = 5'h04,
      ST_CLEAR = 5'h08,
      ST_READ  = 5'h10
   } seq_state_type;

   // one request to the flash array, all fields valid with the strobes
   typedef struct packed {
      logic        wr_valid;
      logic        erase;
      logic        rd_req;
      logic [11:0] addr;
      logic [15:0] wdata;
   } flash_req_type;

endpackage

// file: rtl/write_buffer_mem.sv
`timescale 1ns/10ps
`default_nettype none

module write_buffer_mem #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned AW    = 5
) (
   input  wire  logic             clk,
   input  wire  logic             we,
   input  wire  logic [AW-1:0]    waddr,
   input  wire  logic [WIDTH-1:0] wdata,
   input  wire  logic             re,
   input  wire  logic [AW-1:0]    raddr,
   output logic       [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= mem[raddr];
      end
   end

endmodule
`default_nettype wire

// file: rtl/iap_flash_control_regs.sv
// Notes on behaviour
// R01: software cannot set the enabled status bit
// R02: clearing enabled bit disables erase and write
// R03: mode field codes write, erase, read, enable
// R04: software runs enable procedure before erase/write
// R05: trigger starts timer, cleared at timeout
// R06: software writes key before timer expires
// R07: write initiate runs operation, cleared when done
// R08: reads happen only with read enable set
// R09: read initiate reads one word, then clears
// R10: software never sets three initiate bits together
// R11: processor halted while an operation runs
// R12: software checks slow clock before erase/write
// R13: pattern 55H in reset key resets chip
// R14: time select picks erase and write durations
// R15: buffer clear bit clears buffer, then self-clears
// R16: twelve-bit address split over two registers
// R17: unimplemented high bits read as zero
// R18: low data byte write only stores itself
// R19: high byte write loads buffer, increments address
// R20: key is six fixed bytes in words 1..3
// R21: address increment stops at page last word
// R22: buffer cleared automatically after each write
// R23: enabled bit set only on valid key in time
// R24: erase mode erases page from address 11..5
`include "iap_flash_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module iap_flash_control_regs #(
   parameter int unsigned ERASE0_CYC  = `ERASE_TIME0_CYC,
   parameter int unsigned WRITE0_CYC  = `WRITE_TIME0_CYC,
   parameter int unsigned ERASE1_CYC  = `ERASE_TIME1_CYC,
   parameter int unsigned WRITE1_CYC  = `WRITE_TIME1_CYC,
   parameter int unsigned EN_TIMEOUT  = `ENABLE_TIMEOUT_CYC,
   parameter int unsigned READ_LAT    = `READ_CYC,
   parameter int unsigned CNT_W       = 20,
   parameter int unsigned PAGE_WORDS  = 32
) (
   input  wire  logic                          clk,
   input  wire  logic                          rst,
   input  wire  logic [3:0]                    reg_idx,
   input  wire  logic                          reg_wr,
   input  wire  logic                          reg_rd,
   input  wire  logic [7:0]                    reg_wdata,
   output logic       [7:0]                    reg_rdata,
   output iap_flash_pkg::flash_req_type        flash_req,
   input  wire  logic [15:0]                   flash_rd_data,
   output logic                                cpu_halt,
   output logic                                chip_reset_req
);

   localparam int unsigned IW = $clog2(PAGE_WORDS) + 1;

   iap_flash_pkg::seq_state_type state_r;
   iap_flash_pkg::flash_req_type flash_req_r;

   logic             en_r;
   logic [2:0]       mode_r;
   logic             trig_r;
   logic             winit_r;
   logic             rden_r;
   logic             rinit_r;
   logic [7:0]       key_r;
   logic             optime_r;
   logic             bclr_r;
   logic [11:0]      addr_r;
   logic [7:0]       dlo_r [4];
   logic [7:0]       dhi_r [4];
   logic [31:0]      tag_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] timer_r;
   logic [IW-1:0]    idx_r;
   logic             is_erase_r;
   logic [7:0]       rdata_r;
   logic             chip_reset_r;

   logic             wr_ctrl;
   logic             wr_key;
   logic             wr_tb;
   logic             wr_alo;
   logic             wr_ahi;
   logic [3:0]       wr_dlo;
   logic [3:0]       wr_dhi;
   logic [2:0]       wmode;
   logic             start_wr;
   logic             start_rd;
   logic             start_clr;
   logic             key_ok;
   logic             en_set;
   logic             load_buf;
   logic             rd_cap;
   logic             clr_done;
   logic             erase_done;
   logic             mem_we;
   logic [4:0]       mem_waddr;
   logic [15:0]      mem_wdata;
   logic             mem_re;
   logic [15:0]      mem_rdata;
   logic [4:0]       prog_word;
   logic [7:0]       rd_mux;

   // register write decode
   always_comb begin
      wr_ctrl = 1'b0;
      wr_key  = 1'b0;
      wr_tb   = 1'b0;
      wr_alo  = 1'b0;
      wr_ahi  = 1'b0;
      wr_dlo  = 4'h0;
      wr_dhi  = 4'h0;
      if (reg_wr && reg_idx == `IDX_FLASH_CTRL_MODE) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_CHIP_RESET_KEY) begin
         wr_key = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_FLASH_TIMING_BUFFER_CTRL) begin
         wr_tb = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_FLASH_ADDR_LOW) begin
         wr_alo = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_FLASH_ADDR_HIGH) begin
         wr_ahi = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD0_LOW) begin
         wr_dlo[0] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD0_HIGH) begin
         wr_dhi[0] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD1_LOW) begin
         wr_dlo[1] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD1_HIGH) begin
         wr_dhi[1] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD2_LOW) begin
         wr_dlo[2] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD2_HIGH) begin
         wr_dhi[2] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD3_LOW) begin
         wr_dlo[3] = 1'b1;
      end else if (reg_wr && reg_idx == `IDX_DATA_WORD3_HIGH) begin
         wr_dhi[3] = 1'b1;
      end
   end

   assign wmode = reg_wdata[`CM_MODE_HI:`CM_MODE_LO];

   // operation starts; a new mode written with the trigger takes effect at once
   assign start_wr  = state_r == iap_flash_pkg::ST_IDLE && wr_ctrl
                      && reg_wdata[`CM_WRITE_INITIATE] && en_r
                      && (wmode == iap_flash_pkg::OP_WRITE
                          || wmode == iap_flash_pkg::OP_ERASE); // R07 R02
   assign start_rd  = state_r == iap_flash_pkg::ST_IDLE && wr_ctrl
                      && reg_wdata[`CM_READ_INITIATE] && rden_r
                      && wmode == iap_flash_pkg::OP_READ; // R08 R03
   assign start_clr = state_r == iap_flash_pkg::ST_IDLE && wr_tb
                      && reg_wdata[`TB_BUFFER_CLEAR]; // R15

   assign key_ok = dlo_r[1] == `KEY_WORD1_LOW && dlo_r[2] == `KEY_WORD2_LOW
                   && dlo_r[3] == `KEY_WORD3_LOW && dhi_r[1] == `KEY_WORD1_HIGH
                   && dhi_r[2] == `KEY_WORD2_HIGH && dhi_r[3] == `KEY_WORD3_HIGH; // R20
   assign en_set = trig_r && mode_r == iap_flash_pkg::OP_ENABLE && key_ok; // R23

   assign load_buf   = wr_dhi[0] && en_r; // R19
   assign rd_cap     = state_r == iap_flash_pkg::ST_READ && cnt_r == '0;
   assign clr_done   = state_r == iap_flash_pkg::ST_CLEAR
                       && idx_r == IW'(PAGE_WORDS - 1);
   assign erase_done = state_r == iap_flash_pkg::ST_WAIT && cnt_r == '0 && is_erase_r;

   // the core is stalled for the whole operation
   assign cpu_halt = state_r != iap_flash_pkg::ST_IDLE; // R11

   // erase/write enabled status: hardware set wins over software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         en_r <= 1'b0;
      end else if (en_set) begin
         en_r <= 1'b1; // R23
      end else if (wr_ctrl && !reg_wdata[`CM_ERASE_WRITE_ENABLED]) begin
         en_r <= 1'b0; // R02 R01
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_r <= `RST_MODE;
         rden_r <= 1'b0;
      end else if (wr_ctrl) begin
         mode_r <= wmode; // R03
         rden_r <= reg_wdata[`CM_READ_ENABLE]; // R08
      end
   end

   // enable procedure trigger and its timeout timer
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_r  <= 1'b0;
         timer_r <= '0;
      end else if (wr_ctrl && reg_wdata[`CM_ENABLE_PROC_TRIGGER] && !trig_r) begin
         trig_r  <= 1'b1; // R05
         timer_r <= '0;
      end else if (trig_r && timer_r == CNT_W'(EN_TIMEOUT - 1)) begin
         trig_r  <= 1'b0; // R05
         timer_r <= '0;
      end else if (trig_r) begin
         timer_r <= timer_r + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         winit_r <= 1'b0;
      end else if (start_wr) begin
         winit_r <= 1'b1; // R07
      end else if (clr_done || erase_done) begin
         winit_r <= 1'b0; // R07
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rinit_r <= 1'b0;
      end else if (start_rd) begin
         rinit_r <= 1'b1; // R09
      end else if (rd_cap) begin
         rinit_r <= 1'b0; // R09
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         optime_r <= 1'b0;
      end else if (wr_tb) begin
         optime_r <= reg_wdata[`TB_OP_TIME_SELECT]; // R14
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bclr_r <= 1'b0;
      end else if (start_clr) begin
         bclr_r <= 1'b1; // R15
      end else if (clr_done) begin
         bclr_r <= 1'b0; // R15
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         key_r        <= `RST_BYTE;
         chip_reset_r <= 1'b0;
      end else begin
         chip_reset_r <= wr_key && reg_wdata == `CHIP_RESET_PATTERN; // R13
         if (wr_key) begin
            key_r <= reg_wdata;
         end
      end
   end
   assign chip_reset_req = chip_reset_r;

   // address pair with page-bounded auto-increment
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r <= `RST_ADDR;
      end else if (wr_alo) begin
         addr_r[7:0] <= reg_wdata; // R16
      end else if (wr_ahi) begin
         addr_r[11:8] <= reg_wdata[`ADDR_HIGH_BITS-1:0]; // R16
      end else if (wr_dhi[0] && addr_r[4:0] != `PAGE_LAST_WORD) begin
         addr_r <= addr_r + 12'h001; // R19 R21
      end
   end

   // data word registers; word 0 also receives read results
   generate
      for (genvar i = 0; i < 4; i++) begin : g_word
         always_ff @(posedge clk) begin
            if (rst) begin
               dlo_r[i] <= `RST_BYTE;
               dhi_r[i] <= `RST_BYTE;
            end else if (i == 0 && rd_cap) begin
               dlo_r[i] <= flash_rd_data[7:0]; // R09
               dhi_r[i] <= flash_rd_data[15:8];
            end else begin
               if (wr_dlo[i]) begin
                  dlo_r[i] <= reg_wdata; // R18
               end
               if (wr_dhi[i]) begin
                  dhi_r[i] <= reg_wdata;
               end
            end
         end
      end
   endgenerate

   // tag bits mark which buffer words were loaded for the next write; erase clears them all
   always_ff @(posedge clk) begin
      if (rst) begin
         tag_r <= '0;
      end else if (erase_done) begin
         tag_r <= '0;
      end else if (state_r == iap_flash_pkg::ST_CLEAR) begin
         tag_r[idx_r[4:0]] <= 1'b0; // R22 R15
      end else if (load_buf) begin
         tag_r[addr_r[4:0]] <= 1'b1; // R19
      end
   end

   // sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r    <= iap_flash_pkg::ST_IDLE;
         cnt_r      <= '0;
         idx_r      <= '0;
         is_erase_r <= 1'b0;
      end else begin
         case (state_r)
            iap_flash_pkg::ST_IDLE: begin
               idx_r <= '0;
               if (start_rd) begin
                  state_r <= iap_flash_pkg::ST_READ;
                  cnt_r   <= CNT_W'(READ_LAT - 1);
               end else if (start_wr && wmode == iap_flash_pkg::OP_ERASE) begin
                  state_r    <= iap_flash_pkg::ST_WAIT; // R24
                  is_erase_r <= 1'b1;
                  cnt_r      <= optime_r ? CNT_W'(ERASE1_CYC - 1)
                                         : CNT_W'(ERASE0_CYC - 1); // R14
               end else if (start_wr) begin
                  state_r    <= iap_flash_pkg::ST_PROG;
                  is_erase_r <= 1'b0;
               end else if (start_clr) begin
                  state_r <= iap_flash_pkg::ST_CLEAR;
               end
            end
            iap_flash_pkg::ST_PROG: begin
               idx_r <= idx_r + IW'(1);
               if (idx_r == IW'(PAGE_WORDS)) begin
                  state_r <= iap_flash_pkg::ST_WAIT;
                  cnt_r   <= optime_r ? CNT_W'(WRITE1_CYC - 1)
                                      : CNT_W'(WRITE0_CYC - 1); // R14
               end
            end
            iap_flash_pkg::ST_WAIT: begin
               idx_r <= '0;
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end else if (is_erase_r) begin
                  state_r <= iap_flash_pkg::ST_IDLE;
               end else begin
                  state_r <= iap_flash_pkg::ST_CLEAR; // R22
               end
            end
            iap_flash_pkg::ST_CLEAR: begin
               idx_r <= idx_r + IW'(1);
               if (clr_done) begin
                  state_r <= iap_flash_pkg::ST_IDLE;
               end
            end
            iap_flash_pkg::ST_READ: begin
               if (cnt_r != '0) begin
                  cnt_r <= cnt_r - CNT_W'(1);
               end else begin
                  state_r <= iap_flash_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= iap_flash_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // buffer ports: clear writes zeros, otherwise word 0 high-byte writes load a word
   always_comb begin
      mem_we    = load_buf;
      mem_waddr = addr_r[4:0];
      mem_wdata = {reg_wdata, dlo_r[0]}; // R19
      if (state_r == iap_flash_pkg::ST_CLEAR) begin
         mem_we    = 1'b1; // R15 R22
         mem_waddr = idx_r[4:0];
         mem_wdata = 16'h0000;
      end
   end

   assign mem_re    = state_r == iap_flash_pkg::ST_PROG && idx_r < IW'(PAGE_WORDS);
   assign prog_word = 5'(idx_r - IW'(1));

   write_buffer_mem #(
      .WIDTH (16),
      .DEPTH (PAGE_WORDS),
      .AW    (5)
   ) u_wbuf (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .re    (mem_re),
      .raddr (idx_r[4:0]),
      .rdata (mem_rdata)
   );

   // requests to the flash array
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_req_r <= '0;
      end else begin
         flash_req_r.rd_req   <= start_rd; // R09
         flash_req_r.erase    <= start_wr && wmode == iap_flash_pkg::OP_ERASE; // R24
         flash_req_r.wr_valid <= state_r == iap_flash_pkg::ST_PROG
                                 && idx_r != '0 && tag_r[prog_word]; // R07
         if (start_rd) begin
            flash_req_r.addr <= addr_r;
         end else if (start_wr) begin
            flash_req_r.addr <= {addr_r[11:5], 5'h00}; // R24
         end else if (state_r == iap_flash_pkg::ST_PROG) begin
            flash_req_r.addr  <= {addr_r[11:5], prog_word};
            flash_req_r.wdata <= mem_rdata;
         end
      end
   end
   assign flash_req = flash_req_r;

   // register read mux
   always_comb begin
      rd_mux = 8'h00;
      if (reg_idx == `IDX_FLASH_CTRL_MODE) begin
         rd_mux = {en_r, mode_r, trig_r, winit_r, rden_r, rinit_r};
      end else if (reg_idx == `IDX_CHIP_RESET_KEY) begin
         rd_mux = key_r;
      end else if (reg_idx == `IDX_FLASH_TIMING_BUFFER_CTRL) begin
         rd_mux = {6'h00, optime_r, bclr_r}; // R17
      end else if (reg_idx == `IDX_FLASH_ADDR_LOW) begin
         rd_mux = addr_r[7:0];
      end else if (reg_idx == `IDX_FLASH_ADDR_HIGH) begin
         rd_mux = {4'h0, addr_r[11:8]}; // R17
      end else if (reg_idx == `IDX_DATA_WORD0_LOW) begin
         rd_mux = dlo_r[0];
      end else if (reg_idx == `IDX_DATA_WORD0_HIGH) begin
         rd_mux = dhi_r[0];
      end else if (reg_idx == `IDX_DATA_WORD1_LOW) begin
         rd_mux = dlo_r[1];
      end else if (reg_idx == `IDX_DATA_WORD1_HIGH) begin
         rd_mux = dhi_r[1];
      end else if (reg_idx == `IDX_DATA_WORD2_LOW) begin
         rd_mux = dlo_r[2];
      end else if (reg_idx == `IDX_DATA_WORD2_HIGH) begin
         rd_mux = dhi_r[2];
      end else if (reg_idx == `IDX_DATA_WORD3_LOW) begin
         rd_mux = dlo_r[3];
      end else if (reg_idx == `IDX_DATA_WORD3_HIGH) begin
         rd_mux = dhi_r[3];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= rd_mux;
      end
   end
   assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// file: tb/iap_flash_control_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none

module iap_flash_control_regs_properties (
   input wire logic                         clk,
   input wire logic                         rst,
   input wire logic [3:0]                   reg_idx,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_wdata,
   input wire logic [7:0]                   reg_rdata,
   input wire iap_flash_pkg::flash_req_type flash_req,
   input wire logic [15:0]                  flash_rd_data,
   input wire logic                         cpu_halt,
   input wire logic                         chip_reset_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_key_reset;
      reg_wr && reg_idx == 4'h1 && reg_wdata == 8'h55 |=> chip_reset_req;
   endproperty
   a_key_reset: assert property (p_key_reset) else $error("no reset pulse");
   property p_reset_cause;
      chip_reset_req |-> $past(reg_wr && reg_idx == 4'h1 && reg_wdata == 8'h55);
   endproperty
   a_reset_cause: assert property (p_reset_cause) else $error("stray reset");
   property p_op_halt;
      flash_req.wr_valid || flash_req.erase || flash_req.rd_req |-> cpu_halt;
   endproperty
   a_op_halt: assert property (p_op_halt) else $error("array busy, core free");
   property p_erase_page;
      flash_req.erase |-> flash_req.addr[4:0] == 5'h00 && !flash_req.wr_valid;
   endproperty
   a_erase_page: assert property (p_erase_page) else $error("bad erase address");
   property p_read_cause;
      flash_req.rd_req |-> $past(reg_wr && reg_idx == 4'h0 && reg_wdata[0] && reg_wdata[6:4] == 3'h3);
   endproperty
   a_read_cause: assert property (p_read_cause) else $error("unrequested read");
   property p_read_done;
      $rose(flash_req.rd_req) |-> ##[1:4] !cpu_halt;
   endproperty
   a_read_done: assert property (p_read_done) else $error("read never ends");
   property p_halt_start;
      $rose(cpu_halt) |-> $past(reg_wr && (reg_idx == 4'h0 || reg_idx == 4'h2));
   endproperty
   a_halt_start: assert property (p_halt_start) else $error("halt without trigger");
   property p_addr_hi;
      reg_rd && reg_idx == 4'h4 |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_addr_hi: assert property (p_addr_hi) else $error("address high bits set");
   property p_timing_hi;
      reg_rd && reg_idx == 4'h2 |=> reg_rdata[7:2] == 6'h00;
   endproperty
   a_timing_hi: assert property (p_timing_hi) else $error("timing high bits set");
endmodule

`default_nettype wire

// file: tb/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none

module flash_array_model (
   input  wire logic                         clk,
   input  wire iap_flash_pkg::flash_req_type flash_req,
   output logic                 [15:0]       flash_rd_data
);
   int unsigned wr_cnt = 0;
   int unsigned erase_cnt = 0;
   logic [11:0] last_addr = 12'h000;
   logic [15:0] last_data = 16'h0000;
   logic [15:0] junk_r = 16'h0000;
   logic [11:0] rd_addr_r = 12'h000;
   logic        rd_hold_r = 1'b0;
   // word stands the cycle after the read strobe; otherwise a changing pattern
   assign flash_rd_data = rd_hold_r ? {4'hC, rd_addr_r} : junk_r;
   always @(posedge clk) begin
      junk_r <= junk_r + 16'h3579;
      rd_hold_r <= flash_req.rd_req;
      if (flash_req.rd_req) rd_addr_r <= flash_req.addr;
      if (flash_req.wr_valid) begin
         wr_cnt <= wr_cnt + 1;
         last_addr <= flash_req.addr;
         last_data <= flash_req.wdata;
      end
      if (flash_req.erase) begin
         erase_cnt <= erase_cnt + 1;
         last_addr <= flash_req.addr;
      end
   end
endmodule

`default_nettype wire

// file: tb/iap_flash_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module iap_flash_control_regs_tb;
   localparam int unsigned E0 = 30;
   localparam int unsigned E1 = 50;
   logic                         clk = 1'b0;
   logic                         rst = 1'b1;
   logic [3:0]                   reg_idx = 4'h0;
   logic                         reg_wr = 1'b0;
   logic                         reg_rd = 1'b0;
   logic [7:0]                   reg_wdata = 8'h00;
   logic [7:0]                   reg_rdata;
   iap_flash_pkg::flash_req_type flash_req;
   logic [15:0]                  flash_rd_data;
   logic                         cpu_halt;
   logic                         chip_reset_req;
   int                           miscompares = 0;
   int                           samples_checked = 0;
   int                           n0;
   int                           n1;

   always #4 clk = ~clk;

   iap_flash_control_regs #(.ERASE0_CYC(E0), .WRITE0_CYC(20), .ERASE1_CYC(E1),
      .WRITE1_CYC(40), .EN_TIMEOUT(24)) dut_u (.clk(clk), .rst(rst), .reg_idx(reg_idx),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .flash_req(flash_req), .flash_rd_data(flash_rd_data), .cpu_halt(cpu_halt),
      .chip_reset_req(chip_reset_req));
   flash_array_model model_u (.clk(clk), .flash_req(flash_req), .flash_rd_data(flash_rd_data));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      @(posedge clk);
      reg_idx <= idx;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
      @(posedge clk);
      reg_idx <= idx;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   // counts cycles until the sequencer releases the core
   task automatic wait_idle(output int n);
      n = 0;
      @(posedge clk);
      #1;
      while (cpu_halt !== 1'b0 && n < 5000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 5000) miscompares++;
   endtask
   task automatic close_out();
      $display("checks=%0d miscompares=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(8 * 20000);
      miscompares++;
      close_out();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h00);
      wr(4'h4, 8'hFF);
      rd(4'h4, 8'h0F);
      wr(4'h0, 8'h68);
      wr(4'h7, 8'h00);
      wr(4'h9, 8'h0D);
      wr(4'hB, 8'hC3);
      wr(4'h8, 8'h04);
      wr(4'hA, 8'h09);
      wr(4'hC, 8'h40);
      repeat (30) @(posedge clk);
      rd(4'h0, 8'hE0);
      wr(4'h3, 8'h1E);
      wr(4'h4, 8'h00);
      wr(4'h5, 8'h34);
      rd(4'h3, 8'h1E);
      wr(4'h6, 8'h12);
      wr(4'h5, 8'h78);
      wr(4'h6, 8'h56);
      rd(4'h3, 8'h1F);
      wr(4'h0, 8'h84);
      wait_idle(n0);
      chk(16'(model_u.wr_cnt), 16'h0002);
      chk({4'h0, model_u.last_addr}, 16'h001F);
      chk(model_u.last_data, 16'h5678);
      rd(4'h0, 8'h80);
      wr(4'h0, 8'h84);
      wait_idle(n0);
      chk(16'(model_u.wr_cnt), 16'h0002);
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h94);
      wait_idle(n0);
      wr(4'h2, 8'h02);
      wr(4'h0, 8'h94);
      wait_idle(n1);
      chk(16'(n1 - n0), 16'(E1 - E0));
      chk(16'(model_u.erase_cnt), 16'h0002);
      chk({4'h0, model_u.last_addr}, 16'h0000);
      wr(4'h2, 8'h03);
      wait_idle(n0);
      rd(4'h2, 8'h02);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h04);
      @(posedge clk);
      #1;
      chk({15'h0000, cpu_halt}, 16'h0000);
      wr(4'h0, 8'h31);
      wait_idle(n0);
      rd(4'h0, 8'h30);
      wr(4'h0, 8'h32);
      wr(4'h3, 8'h45);
      wr(4'h0, 8'h33);
      wait_idle(n0);
      rd(4'h5, 8'h45);
      rd(4'h6, 8'hC0);
      rd(4'h0, 8'h32);
      wr(4'h1, 8'h55);
      #1;
      chk({15'h0000, chip_reset_req}, 16'h0001);
      close_out();
   end
endmodule

bind iap_flash_control_regs iap_flash_control_regs_properties props_u (.clk(clk), .rst(rst),
   .reg_idx(reg_idx), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .flash_req(flash_req), .flash_rd_data(flash_rd_data),
   .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req));

`default_nettype wire
